// [src/lrnc_regs.svh]
// offsets, field positions, reset values and timing counts for the legacy reset/nmi block
// Operation
// - 4D1h bits 7,6,4:1 pick edge/level mode
// - IRQ13 and IRQ8 always edge sensitive
// - read of 60h releases IRQ12, clears IRQ1
// - enabled mouse input drives IRQ12
// - 60h and F0h cycles still reach ISA
// - write F0h asserts ignore, drops IRQ13
// - ignore output only while float error active
// - CF9h resets 00h, bit 2 rise starts reset
// - bit 1 picks hard or soft reset
// - hard reset drives cpu, pci, isa resets
// - power good starts a hard reset
// - bit 2 of CF9h reads zero
// - enable/disable bit write 1 clears status
// - nmi stays high while sources pending
// - mask toggle gives a fresh nmi edge
// - global mask blocks all nmi sources
// - serr sets bit 7, iochk bit 6
// - 061h bits 3,2 enable or clear sources
// - 070h bit 7 masks nmi, resets 1
`ifndef LRNC_REGS_SVH
`define LRNC_REGS_SVH
// ==========================================================
// port addresses
`define LRNC_ADDR_IRQ_RELEASE 16'h0060
`define LRNC_ADDR_NMI_STATUS  16'h0061
`define LRNC_ADDR_NMI_MASK    16'h0070
`define LRNC_ADDR_COPROC_ERR  16'h00f0
`define LRNC_ADDR_UPPER_TRIG  16'h04d1
`define LRNC_ADDR_RESET_REQ   16'h0cf9
// ==========================================================
// field positions and masks
`define LRNC_TRIG_WR_MASK     8'hde
`define LRNC_TRIG_RESET       8'h00
`define LRNC_RST_TYPE_BIT     1
`define LRNC_RST_TRIG_BIT     2
`define LRNC_NMI_SERR_DIS_BIT 2
`define LRNC_NMI_IOCHK_DIS_BIT 3
`define LRNC_NMI_MASK_BIT     7
`define LRNC_TRIG_IRQ13_POS   5
`define LRNC_TRIG_IRQ8_POS    0
// ==========================================================
// timing: times in ns, counts rounded up at the clock rate
`define LRNC_CLK_MHZ          40
`define LRNC_HARD_RST_NS      2000
`define LRNC_SOFT_RST_NS      500
`define LRNC_HARD_RST_CYC     ((`LRNC_HARD_RST_NS * `LRNC_CLK_MHZ + 999) / 1000)
`define LRNC_SOFT_RST_CYC     ((`LRNC_SOFT_RST_NS * `LRNC_CLK_MHZ + 999) / 1000)
`endif

// [src/lrnc_pkg.sv]
// types shared by the legacy reset/nmi block
package lrnc_pkg;
  // reset sequencer states
  typedef enum logic [1:0] {
    LRNC_RST_IDLE = 2'b00,
    LRNC_RST_HARD = 2'b01,
    LRNC_RST_SOFT = 2'b10
  } lrnc_rst_state_t;
endpackage

// [src/lrnc_sync.sv]
// three-stage pin synchroniser, output moves once stages two and three agree
module lrnc_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;

  if (W < 1) begin : g_bad_w
    $error("lrnc_sync: width must be at least one");
  end

  // ==========================================================
  // per-bit chain; stage one is read only by stage two
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        s1_ff[i]  <= RST_VAL[i];
        s2_ff[i]  <= RST_VAL[i];
        s3_ff[i]  <= RST_VAL[i];
        out_ff[i] <= RST_VAL[i];
      end else begin
        s1_ff[i] <= pin_in[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        // agreement filter drops a single metastable sample
        if (s2_ff[i] == s3_ff[i]) begin
          out_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign pin_out = out_ff;
endmodule

// [src/lrnc_top.sv]
// legacy system-control ports: trigger mode, irq release, coprocessor error, reset, nmi
`include "lrnc_regs.svh"
module lrnc_top #(
  parameter int unsigned HARD_CYC = `LRNC_HARD_RST_CYC,
  parameter int unsigned SOFT_CYC = `LRNC_SOFT_RST_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rd_hit,
  output logic             isa_fwd,
  input  wire logic        mouse_irq_enable,
  input  wire logic        mouse_irq_input,
  input  wire logic        float_error_n_in,
  input  wire logic        serr_n_in,
  input  wire logic        iochk_n_in,
  input  wire logic        power_good_in,
  output logic             irq12_out,
  output logic             irq1_clear,
  output logic             irq13_req,
  output logic             ignore_numeric_error_n_out,
  output logic      [7:0]  edge_level_select,
  output logic             processor_reset_out,
  output logic             pci_reset_n_out,
  output logic             isa_reset_drive,
  output logic             nmi_out
);
  // ==========================================================
  // elaboration checks
  if (HARD_CYC < 1 || HARD_CYC > 65535 || SOFT_CYC < 1 || SOFT_CYC > 65535) begin : g_bad
    $error("lrnc_top: reset lengths must be 1..65535 cycles");
  end

  function automatic logic at(input logic [15:0] a, input logic [15:0] port);
    return a == port;
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [4:0] pins_s;
  logic       mouse_s;
  logic       fpe_n_s;
  logic       serr_n_s;
  logic       iochk_n_s;
  logic       pg_s;
  lrnc_sync #(.W(5), .RST_VAL(5'h0e)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .pin_in  ({power_good_in, iochk_n_in, serr_n_in, float_error_n_in, mouse_irq_input}),
    .pin_out (pins_s)
  );
  assign mouse_s   = pins_s[0];
  assign fpe_n_s   = pins_s[1];
  assign serr_n_s  = pins_s[2];
  assign iochk_n_s = pins_s[3];
  assign pg_s      = pins_s[4];

  // previous synced values for edge detection
  logic mouse_q_ff;
  logic fpe_n_q_ff;
  logic serr_n_q_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      mouse_q_ff  <= 1'b0;
      fpe_n_q_ff  <= 1'b1;
      serr_n_q_ff <= 1'b1;
    end else begin
      mouse_q_ff  <= mouse_s;
      fpe_n_q_ff  <= fpe_n_s;
      serr_n_q_ff <= serr_n_s;
    end
  end

  logic mouse_rise;
  logic fpe_fall;
  logic serr_fall;
  assign mouse_rise = mouse_s & ~mouse_q_ff;
  assign fpe_fall   = ~fpe_n_s & fpe_n_q_ff;
  assign serr_fall  = ~serr_n_s & serr_n_q_ff;

  // ==========================================================
  // address decode
  logic rd60;
  logic wr61;
  logic wr70;
  logic wrf0;
  logic wr4d1;
  logic wrcf9;
  assign rd60  = io_rd & at(io_addr, `LRNC_ADDR_IRQ_RELEASE);
  assign wr61  = io_wr & at(io_addr, `LRNC_ADDR_NMI_STATUS);
  assign wr70  = io_wr & at(io_addr, `LRNC_ADDR_NMI_MASK);
  assign wrf0  = io_wr & at(io_addr, `LRNC_ADDR_COPROC_ERR);
  assign wr4d1 = io_wr & at(io_addr, `LRNC_ADDR_UPPER_TRIG);
  assign wrcf9 = io_wr & at(io_addr, `LRNC_ADDR_RESET_REQ);

  // ==========================================================
  // upper trigger-mode register; reserved bits forced to zero
  logic [7:0] trig_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_ff <= `LRNC_TRIG_RESET;
    end else if (wr4d1) begin
      trig_ff <= io_wdata & `LRNC_TRIG_WR_MASK;
    end
  end

  // irq13 and irq8 carry no select bit, so they stay edge
  logic [7:0] els_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      els_ff <= `LRNC_TRIG_RESET;
    end else begin
      els_ff                       <= trig_ff;
      els_ff[`LRNC_TRIG_IRQ13_POS] <= 1'b0;
      els_ff[`LRNC_TRIG_IRQ8_POS]  <= 1'b0;
    end
  end

  // ==========================================================
  // mouse and keyboard interrupt release; a new edge beats the release
  logic irq12_ff;
  logic irq1_clr_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      irq12_ff    <= 1'b0;
      irq1_clr_ff <= 1'b0;
    end else begin
      irq1_clr_ff <= rd60;
      if (mouse_irq_enable && mouse_rise) begin
        irq12_ff <= 1'b1;
      end else if (rd60) begin
        irq12_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // coprocessor error: irq13 request and ignore-numeric-error
  logic irq13_ff;
  logic ign_ff;
  logic ignore_n_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      irq13_ff <= 1'b0;
    end else if (fpe_fall) begin
      irq13_ff <= 1'b1; // fresh error wins over the write
    end else if (wrf0) begin
      irq13_ff <= 1'b0;
    end
  end

  // latch holds only while the error input is active
  always_ff @(posedge clk) begin
    if (rst) begin
      ign_ff      <= 1'b0;
      ignore_n_ff <= 1'b1;
    end else begin
      ign_ff      <= (wrf0 | ign_ff) & ~fpe_n_s;
      ignore_n_ff <= ~((wrf0 | ign_ff) & ~fpe_n_s);
    end
  end

  // ==========================================================
  // reset request register and sequencer
  logic                     req_type_ff;
  logic                     req_trig_ff;
  logic                     req_start;
  lrnc_pkg::lrnc_rst_state_t state_ff;
  lrnc_pkg::lrnc_rst_state_t nxt_state;
  logic [15:0]              cnt_ff;
  logic [15:0]              nxt_cnt;

  assign req_start = wrcf9 & io_wdata[`LRNC_RST_TRIG_BIT] & ~req_trig_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      req_type_ff <= 1'b0;
      req_trig_ff <= 1'b0;
    end else if (wrcf9) begin
      req_type_ff <= io_wdata[`LRNC_RST_TYPE_BIT];
      req_trig_ff <= io_wdata[`LRNC_RST_TRIG_BIT];
    end
  end

  // power loss holds a hard reset; it counts out once power is good
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (!pg_s) begin
      nxt_state = lrnc_pkg::LRNC_RST_HARD;
      nxt_cnt   = 16'(HARD_CYC);
    end else if (req_start && io_wdata[`LRNC_RST_TYPE_BIT]) begin
      nxt_state = lrnc_pkg::LRNC_RST_HARD;
      nxt_cnt   = 16'(HARD_CYC);
    end else if (req_start) begin
      nxt_state = lrnc_pkg::LRNC_RST_SOFT;
      nxt_cnt   = 16'(SOFT_CYC);
    end else begin
      case (state_ff)
        lrnc_pkg::LRNC_RST_IDLE: nxt_state = lrnc_pkg::LRNC_RST_IDLE;
        lrnc_pkg::LRNC_RST_HARD,
        lrnc_pkg::LRNC_RST_SOFT: begin
          if (cnt_ff <= 16'h0001) begin
            nxt_state = lrnc_pkg::LRNC_RST_IDLE;
            nxt_cnt   = 16'h0000;
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
        default: nxt_state = lrnc_pkg::LRNC_RST_IDLE;
      endcase
    end
  end

  // outputs are registered from the next state so they switch with it
  logic cpu_rst_ff;
  logic pci_rst_n_ff;
  logic isa_rst_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff     <= lrnc_pkg::LRNC_RST_IDLE;
      cnt_ff       <= 16'h0000;
      cpu_rst_ff   <= 1'b0;
      pci_rst_n_ff <= 1'b1;
      isa_rst_ff   <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      cpu_rst_ff   <= nxt_state != lrnc_pkg::LRNC_RST_IDLE;
      pci_rst_n_ff <= nxt_state != lrnc_pkg::LRNC_RST_HARD;
      isa_rst_ff   <= nxt_state == lrnc_pkg::LRNC_RST_HARD;
    end
  end

  // ==========================================================
  // nmi sources; a status sets only while its source is enabled
  logic serr_dis_ff;
  logic iochk_dis_ff;
  logic serr_st_ff;
  logic iochk_st_ff;
  logic mask_ff;
  logic nmi_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      serr_dis_ff  <= 1'b0;
      iochk_dis_ff <= 1'b0;
      mask_ff      <= 1'b1;
    end else begin
      if (wr61) begin
        serr_dis_ff  <= io_wdata[`LRNC_NMI_SERR_DIS_BIT];
        iochk_dis_ff <= io_wdata[`LRNC_NMI_IOCHK_DIS_BIT];
      end
      if (wr70) begin
        mask_ff <= io_wdata[`LRNC_NMI_MASK_BIT];
      end
    end
  end

  // writing 1 to a disable bit clears that status at once
  always_ff @(posedge clk) begin
    if (rst) begin
      serr_st_ff  <= 1'b0;
      iochk_st_ff <= 1'b0;
    end else begin
      if (wr61 && io_wdata[`LRNC_NMI_SERR_DIS_BIT]) begin
        serr_st_ff <= 1'b0;
      end else if (serr_fall && !serr_dis_ff) begin
        serr_st_ff <= 1'b1;
      end
      if (wr61 && io_wdata[`LRNC_NMI_IOCHK_DIS_BIT]) begin
        iochk_st_ff <= 1'b0;
      end else if (!iochk_n_s && !iochk_dis_ff) begin
        iochk_st_ff <= 1'b1;
      end
    end
  end

  // level output; toggling the mask re-creates the edge the cpu needs
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_ff <= 1'b0;
    end else begin
      nmi_ff <= ~mask_ff & (serr_st_ff | iochk_st_ff);
    end
  end

  // ==========================================================
  // read data and isa forwarding
  logic [7:0] rdata_ff;
  logic       rd_hit_ff;
  logic       fwd_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff  <= 8'h00;
      rd_hit_ff <= 1'b0;
      fwd_ff    <= 1'b0;
    end else begin
      fwd_ff    <= (io_rd | io_wr) & (at(io_addr, `LRNC_ADDR_IRQ_RELEASE)
                   | at(io_addr, `LRNC_ADDR_COPROC_ERR)
                   | at(io_addr, `LRNC_ADDR_NMI_MASK));
      rd_hit_ff <= 1'b0;
      rdata_ff  <= 8'h00;
      if (io_rd) begin
        if (at(io_addr, `LRNC_ADDR_UPPER_TRIG)) begin
          rd_hit_ff <= 1'b1;
          rdata_ff  <= trig_ff;
        end else if (at(io_addr, `LRNC_ADDR_RESET_REQ)) begin
          rd_hit_ff <= 1'b1;
          rdata_ff  <= {6'h00, req_type_ff, 1'b0};
        end else if (at(io_addr, `LRNC_ADDR_NMI_STATUS)) begin
          rd_hit_ff <= 1'b1;
          rdata_ff  <= {serr_st_ff, iochk_st_ff, 2'h0, iochk_dis_ff, serr_dis_ff, 2'h0};
        end
      end
    end
  end

  // ==========================================================
  // outputs
  assign io_rdata                   = rdata_ff;
  assign io_rd_hit                  = rd_hit_ff;
  assign isa_fwd                    = fwd_ff;
  assign irq12_out                  = irq12_ff;
  assign irq1_clear                 = irq1_clr_ff;
  assign irq13_req                  = irq13_ff;
  assign ignore_numeric_error_n_out = ignore_n_ff;
  assign edge_level_select          = els_ff;
  assign processor_reset_out        = cpu_rst_ff;
  assign pci_reset_n_out            = pci_rst_n_ff;
  assign isa_reset_drive            = isa_rst_ff;
  assign nmi_out                    = nmi_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_trig_reserved_zero: assert property (trig_ff[5] == 1'b0 && trig_ff[0] == 1'b0)
    else $error("reserved trigger bits set");
  chk_edge_fixed_lines: assert property (wr4d1 |-> ##2 (!els_ff[5] && !els_ff[0]))
    else $error("irq13 or irq8 not edge");
  chk_rd60_release: assert property (rd60 && !(mouse_irq_enable && mouse_rise)
    |=> !irq12_ff && irq1_clr_ff)
    else $error("read of 60h did not release");
  chk_mouse_to_irq12: assert property (mouse_irq_enable && mouse_rise |=> irq12_ff)
    else $error("mouse edge lost");
  chk_isa_fwd: assert property ((io_rd || io_wr) && (at(io_addr, `LRNC_ADDR_IRQ_RELEASE)
    || at(io_addr, `LRNC_ADDR_COPROC_ERR)) |=> fwd_ff)
    else $error("cycle not forwarded");
  chk_f0_drops_irq13: assert property (wrf0 && !fpe_fall |=> !irq13_ff)
    else $error("irq13 stayed after F0 write");
  chk_ignore_needs_fpe: assert property (!ignore_n_ff |-> $past(!fpe_n_s))
    else $error("ignore output without float error");
  chk_req_start_kind: assert property (req_start && pg_s && io_wdata[`LRNC_RST_TYPE_BIT]
    |=> state_ff == lrnc_pkg::LRNC_RST_HARD ##1 isa_rst_ff)
    else $error("hard reset not started");
  chk_req_read_zero: assert property (io_rd && at(io_addr, `LRNC_ADDR_RESET_REQ)
    |=> rd_hit_ff && !rdata_ff[2])
    else $error("trigger bit read as one");
  chk_hard_pins: assert property (isa_rst_ff |-> cpu_rst_ff && !pci_rst_n_ff)
    else $error("hard reset pins mismatch");
  chk_pg_hard: assert property (!pg_s |=> state_ff == lrnc_pkg::LRNC_RST_HARD)
    else $error("power good did not hold reset");
  chk_nmi_clear: assert property (wr61 && io_wdata[`LRNC_NMI_IOCHK_DIS_BIT] |=> !iochk_st_ff)
    else $error("iochk status not cleared");
  chk_nmi_mask_level: assert property (mask_ff |=> !nmi_ff)
    else $error("nmi not masked");
  chk_nmi_pending: assert property (!mask_ff && (serr_st_ff || iochk_st_ff)
    |=> nmi_ff)
    else $error("nmi dropped while pending");

  cov_soft_reset: cover property (req_start && pg_s && !io_wdata[`LRNC_RST_TYPE_BIT]);
  cov_nmi_rearm: cover property (nmi_ff ##1 !nmi_ff ##[1:20] nmi_ff);
  cov_ignore: cover property (!ignore_n_ff);
  cov_mouse_release: cover property (irq12_ff ##[1:50] rd60);
endmodule

// [verification/lrnc_pin_model.sv]
// board-side model of the pins around the legacy reset and nmi block
module lrnc_pin_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic serr_req,
  input  wire logic iochk_act,
  input  wire logic fpe_act,
  input  wire logic mouse_act,
  input  wire logic pwr_ok,
  output logic      serr_n,
  output logic      iochk_n,
  output logic      float_err_n,
  output logic      mouse_pin,
  output logic      power_good
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] serr_cnt_ff;
  // ==========================================================
  // serr pulse
  // a pci agent only pulses serr; three cycles so the pin synchroniser sees it
  always_ff @(posedge clk) begin
    if (rst) begin
      serr_cnt_ff <= 2'h0;
    end else if (serr_req) begin
      serr_cnt_ff <= 2'h3;
    end else if (serr_cnt_ff != 2'h0) begin
      serr_cnt_ff <= serr_cnt_ff - 2'h1;
    end
  end
  assign serr_n = (serr_cnt_ff == 2'h0);
  // ==========================================================
  // level pins; the error lines are active low on the board
  assign iochk_n     = !iochk_act;
  assign float_err_n = !fpe_act;
  assign mouse_pin   = mouse_act;
  assign power_good  = pwr_ok;
endmodule

// [verification/legacy_reset_nmi_ctrl_bench.sv]
// self-checking bench for the legacy reset and nmi ports
`include "lrnc_regs.svh"
module legacy_reset_nmi_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HARD = 4;
  localparam int unsigned SOFT = 2;
  localparam logic [15:0] A_REL = `LRNC_ADDR_IRQ_RELEASE;
  localparam logic [15:0] A_STS = `LRNC_ADDR_NMI_STATUS;
  localparam logic [15:0] A_MSK = `LRNC_ADDR_NMI_MASK;
  localparam logic [15:0] A_CPE = `LRNC_ADDR_COPROC_ERR;
  localparam logic [15:0] A_TRG = `LRNC_ADDR_UPPER_TRIG;
  localparam logic [15:0] A_RST = `LRNC_ADDR_RESET_REQ;
  logic        clk, rst, io_rd, io_wr, mouse_en, io_rd_hit, isa_fwd;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, els, rd_data;
  logic        irq12, irq1_clr, irq13, ign_n, cpu_rst, pci_rst_n, isa_rst, nmi;
  logic        serr_req, iochk_act, fpe_act, mouse_act, pwr_ok;
  logic        serr_n, iochk_n, fpe_n, mouse_pin, pgood, rd_hit, rd_fwd, rd_clr, p, s;
  int          fail_count, cmp_count, n;

  lrnc_top #(.HARD_CYC(HARD), .SOFT_CYC(SOFT)) DUT (
    .clk(clk), .rst(rst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_hit(io_rd_hit), .isa_fwd(isa_fwd),
    .mouse_irq_enable(mouse_en), .mouse_irq_input(mouse_pin), .float_error_n_in(fpe_n),
    .serr_n_in(serr_n), .iochk_n_in(iochk_n), .power_good_in(pgood), .irq12_out(irq12),
    .irq1_clear(irq1_clr), .irq13_req(irq13), .ignore_numeric_error_n_out(ign_n),
    .edge_level_select(els), .processor_reset_out(cpu_rst), .pci_reset_n_out(pci_rst_n),
    .isa_reset_drive(isa_rst), .nmi_out(nmi));

  lrnc_pin_model pins (
    .clk(clk), .rst(rst), .serr_req(serr_req), .iochk_act(iochk_act), .fpe_act(fpe_act),
    .mouse_act(mouse_act), .pwr_ok(pwr_ok), .serr_n(serr_n), .iochk_n(iochk_n),
    .float_err_n(fpe_n), .mouse_pin(mouse_pin), .power_good(pgood));

  // ==========================================================
  // clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // comparison and closing report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // io cycles: one-cycle strobe, answer sampled just after the next edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    #1;
  endtask

  task automatic io_read(input logic [15:0] a);
    @(posedge clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    rd_data = io_rdata;
    rd_hit  = io_rd_hit;
    rd_fwd  = isa_fwd;
    rd_clr  = irq1_clr;
  endtask

  // waits for a processor reset, notes the other pins, counts its length
  task automatic reset_len();
    int g;
    g = 0;
    n = 0;
    while (cpu_rst !== 1'b1 && g < 4) begin
      tick(1);
      g++;
    end
    p = pci_rst_n;
    s = isa_rst;
    while (cpu_rst === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (n == 200 || g == 4) begin
      fail_count++;
      print_verdict();
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    mouse_en = 1'b0;
    serr_req = 1'b0;
    iochk_act = 1'b0;
    fpe_act = 1'b0;
    mouse_act = 1'b0;
    pwr_ok = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // power-up hard reset, then register defaults
    reset_len();
    check(p, 1'b0);
    check(s, 1'b1);
    io_read(A_TRG);
    check(rd_data, 8'h00);
    check(rd_hit, 1'b1);
    io_read(A_RST);
    check(rd_data, 8'h00);
    // all selectable lines to level, reserved bits written zero; irq13 and irq8 stay edge
    io_write(A_TRG, 8'hde);
    tick(1);
    check(els, 8'hde);
    io_read(A_TRG);
    check(rd_data, 8'hde);
    io_write(A_TRG, 8'h00);
    // hard reset: type first, then trigger
    io_write(A_RST, 8'h02);
    io_read(A_RST);
    check(rd_data, 8'h02);
    check(cpu_rst, 1'b0);
    io_write(A_RST, 8'h06);
    reset_len();
    check(n[7:0], HARD[7:0]);
    check(p, 1'b0);
    check(s, 1'b1);
    io_read(A_RST);
    check(rd_data, 8'h02);
    // trigger bit already one: no new reset
    io_write(A_RST, 8'h06);
    tick(4);
    check(cpu_rst, 1'b0);
    // soft reset touches the processor only
    io_write(A_RST, 8'h00);
    io_write(A_RST, 8'h04);
    reset_len();
    check(n[7:0], SOFT[7:0]);
    check(p, 1'b1);
    check(s, 1'b0);
    // power good dropped mid-run
    @(posedge clk);
    pwr_ok <= 1'b0;
    tick(8);
    check(cpu_rst, 1'b1);
    check(pci_rst_n, 1'b0);
    pwr_ok <= 1'b1;
    reset_len();
    // release port and mouse interrupt
    io_read(A_REL);
    check(rd_fwd, 1'b1);
    check(rd_clr, 1'b1);
    check(rd_hit, 1'b0);
    @(posedge clk);
    mouse_en <= 1'b1;
    mouse_act <= 1'b1;
    tick(8);
    check(irq12, 1'b1);
    io_read(A_REL);
    check(irq12, 1'b0);
    mouse_act <= 1'b0;
    mouse_en <= 1'b0;
    tick(8);
    mouse_act <= 1'b1;
    tick(8);
    check(irq12, 1'b0);
    // coprocessor error port
    io_write(A_CPE, 8'h5a);
    check(isa_fwd, 1'b1);
    tick(2);
    check(ign_n, 1'b1);
    fpe_act <= 1'b1;
    tick(8);
    check(irq13, 1'b1);
    check(ign_n, 1'b1);
    io_write(A_CPE, 8'ha5);
    tick(2);
    check(irq13, 1'b0);
    check(ign_n, 1'b0);
    fpe_act <= 1'b0;
    tick(8);
    check(ign_n, 1'b1);
    // nmi: masked after reset, then the re-arm sequence
    serr_req <= 1'b1;
    tick(1);
    serr_req <= 1'b0;
    tick(10);
    check(nmi, 1'b0);
    io_read(A_STS);
    check(rd_data, 8'h80);
    io_write(A_MSK, 8'h00);
    tick(3);
    check(nmi, 1'b1);
    iochk_act <= 1'b1;
    tick(8);
    io_read(A_STS);
    check(rd_data, 8'hc0);
    io_write(A_STS, 8'h04);
    tick(3);
    io_read(A_STS);
    check(rd_data, 8'h44);
    check(nmi, 1'b1);
    io_write(A_MSK, 8'h80);
    tick(3);
    check(nmi, 1'b0);
    io_write(A_MSK, 8'h00);
    tick(3);
    check(nmi, 1'b1);
    io_write(A_STS, 8'h0c);
    tick(3);
    check(nmi, 1'b0);
    io_read(A_STS);
    check(rd_data, 8'h0c);
    print_verdict();
  end
endmodule
